// file: hw/ccas_params.svh
`ifndef CCAS_PARAMS_SVH
`define CCAS_PARAMS_SVH

// ==========================================
// Timing
`define CCAS_CLK_NS 10
`define CCAS_TICK_NS 3906250
`define CCAS_SWT_NS 10000000

// ==========================================
// Register byte addresses
`define CCAS_A_CTL 8'h00
`define CCAS_A_ALS 8'h04
`define CCAS_A_ALHM 8'h08
`define CCAS_A_SW 8'h0C
`define CCAS_A_SEC 8'h10
`define CCAS_A_HM 8'h14

// ==========================================
// Bit positions and fields
`define CCAS_B_TRMB 15
`define CCAS_B_BSY 6
`define CCAS_B_HLD 5
`define CCAS_B_FMT 4
`define CCAS_B_ADJ 2
`define CCAS_B_RST 1
`define CCAS_B_RUN 0
`define CCAS_B_CLR 4
`define CCAS_B_GO 0
`define CCAS_B_PM 14
`define CCAS_F_HI 14:12
`define CCAS_F_LO 11:8
`define CCAS_F_HT 13:12
`define CCAS_F_MT 6:4
`define CCAS_F_MU 3:0
`define CCAS_F_SWT 15:12
`define CCAS_F_TAP 7:0

// ==========================================
// Values
`define CCAS_HT_RST 2'h1
`define CCAS_HU_RST 4'h2
`define CCAS_ADJ_MIN 3'h3
`define CCAS_DIV_TOP 8'hFF
`define CCAS_D9 4'h9
`define CCAS_D5 3'h5
`define CCAS_TEN 6'h0A
`define CCAS_H23 6'h17
`define CCAS_H11 6'h0B
`define CCAS_H12 6'h0C
`define CCAS_HSIZE_W 3'h2

`endif

// file: hw/ccas_pkg.sv
`default_nettype none
package ccas_pkg;

	typedef enum logic {CCAS_BUS_IDLE, CCAS_BUS_DATA} ccas_bus_t;

	typedef struct packed {
		ccas_bus_t bus;
		logic [7:0] addr;
		logic wr;
		logic rdy;
		logic [31:0] rdata;
		logic [19:0] pre;
		logic [19:0] swpre;
		logic [7:0] div;
		logic hold;
		logic fmt;
		logic adj;
		logic rst;
		logic run;
		logic busy;
		logic pend;
		logic [2:0] st;
		logic [3:0] su;
		logic [2:0] mt;
		logic [3:0] mu;
		logic pm;
		logic [1:0] ht;
		logic [3:0] hu;
		logic [2:0] ast;
		logic [3:0] asu;
		logic apm;
		logic [1:0] aht;
		logic [3:0] ahu;
		logic [2:0] amt;
		logic [3:0] amu;
		logic [3:0] swt;
		logic [3:0] swh;
		logic swgo;
		logic stopwatch_go;
		logic match;
	} ccas_state_t;

endpackage
`default_nettype wire

// file: hw/ccas_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccas_params.svh"

//
// Summary of operation
// - Hold set suspends time counting; clearing it resumes at once.
// - While trim busy, hold stays 0 and writes of 1 are ignored.
// - Format 1 gives 24-hour range, 0 gives 12-hour; hour not rewritten.
// - Adjust 1 starts half-minute correction unless written while busy, reads 1, self-clears within 2/256 s.
// - Subsecond reset clears divider, adjust and hold, then self-clears.
// - Run 1 counts, 0 stops keeping value; run again continues.
// - Second alarm: tens in 14-12, units in 11-8, others zero.
// - Alarm PM bit 14 compared only in 12-hour mode.
// - Alarm hour: tens in 13-12, units in 11-8.
// - Alarm minute: tens in 6-4, units in 3-0.
// - Stopwatch tenths in 15-12, hundredths in 11-8, read-only, reset 0.
// - Stopwatch clear zeroes the count and always reads 0.
// - Stopwatch go starts or stops; stop lands on next stopwatch clock.
// - Second counter: tens 14-12, units 11-8, read/write, reset 0.
// - Second register bits 7-0 are divider taps, cleared by subsecond reset.
// - PM bit forced 0 in 24-hour mode, cleared at next hour step.
// - Hour counter BCD tens and units, resets to 12.
// - Minute counter: tens 6-4, units 3-0, read/write, reset 0.
// - Busy reads 1 for 1/256 s after any count step or correction.
// - Half-minute correction clears seconds, adds a minute from 30 up.
// - Missed seconds during hold give exactly one second after release.
module ccas_top
	import ccas_pkg::*;
#(
	parameter int unsigned TICK_CYC = `CCAS_TICK_NS / `CCAS_CLK_NS,
	parameter int unsigned SW_CYC = `CCAS_SWT_NS / `CCAS_CLK_NS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic trim_busy,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic alarm_match
);

	// ==========================================
	// State
	localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);
	localparam logic [19:0] SW_LAST = 20'(SW_CYC - 1);
	localparam ccas_state_t S_RST = '{
		bus: CCAS_BUS_IDLE,
		rdy: 1'b1,
		ht: `CCAS_HT_RST,
		hu: `CCAS_HU_RST,
		default: '0
	};

	ccas_state_t q;
	ccas_state_t d;
	logic tick;
	logic swtick;
	logic sec_evt;
	logic wr_now;
	logic do_up;
	logic do_adj;
	logic min_up;
	logic hr_up;
	logic [15:0] rv;

	// ==========================================
	// BCD helpers
	function automatic logic [7:0] inc60(input logic [2:0] t, input logic [3:0] u);
		if (u < `CCAS_D9) begin
			return {1'b0, t, u + 4'h1};
		end
		if (t < `CCAS_D5) begin
			return {1'b0, t + 3'h1, 4'h0};
		end
		return 8'h80;
	endfunction

	function automatic logic [6:0] hour_inc(input logic f, input logic p,
		input logic [1:0] t, input logic [3:0] u);
		logic [5:0] h;
		logic [1:0] nt;
		logic np;
		h = 6'(t) * `CCAS_TEN + 6'(u);
		np = p;
		nt = 2'h0;
		if (f) begin
			np = 1'b0;
			h = (h >= `CCAS_H23) ? 6'h00 : h + 6'h01;
		end else if (h == `CCAS_H11) begin
			h = `CCAS_H12;
			np = !p;
		end else if (h >= `CCAS_H12 || h == 6'h00) begin
			h = 6'h01;
		end else begin
			h = h + 6'h01;
		end
		if (h >= `CCAS_TEN) begin
			h = h - `CCAS_TEN;
			nt = 2'h1;
		end
		if (h >= `CCAS_TEN) begin
			h = h - `CCAS_TEN;
			nt = 2'h2;
		end
		return {np, nt, h[3:0]};
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		d = q;
		tick = q.pre == TICK_LAST;
		swtick = q.swpre == SW_LAST;
		sec_evt = tick && q.run && q.div == `CCAS_DIV_TOP;
		wr_now = q.bus == CCAS_BUS_DATA && q.wr;
		do_up = 1'b0;
		do_adj = 1'b0;
		min_up = 1'b0;
		hr_up = 1'b0;
		d.pre = tick ? 20'h00000 : q.pre + 20'h00001;
		d.swpre = swtick ? 20'h00000 : q.swpre + 20'h00001;

		if (tick) begin
			d.div = q.div + 8'h01;
			d.busy = 1'b0;
			if (q.busy && q.adj) begin
				d.adj = 1'b0;
			end
			if (sec_evt && (q.hold || q.busy || q.adj)) begin
				d.pend = 1'b1;
			end
			if (!q.busy && q.adj) begin
				do_adj = 1'b1;
			end else if (!q.busy && !q.hold && (sec_evt || q.pend)) begin
				do_up = 1'b1;
				d.pend = 1'b0;
			end
		end

		if (do_up) begin
			{min_up, d.st, d.su} = inc60(q.st, q.su);
		end
		if (do_adj) begin
			d.st = 3'h0;
			d.su = 4'h0;
			min_up = q.st >= `CCAS_ADJ_MIN;
		end
		if (min_up) begin
			{hr_up, d.mt, d.mu} = inc60(q.mt, q.mu);
		end
		if (hr_up) begin
			{d.pm, d.ht, d.hu} = hour_inc(q.fmt, q.pm, q.ht, q.hu);
		end
		if (do_up || do_adj) begin
			d.busy = 1'b1;
		end

		if (q.rst) begin
			d.div = 8'h00;
			d.pre = 20'h00000;
			d.adj = 1'b0;
			d.hold = 1'b0;
			d.rst = 1'b0;
		end

		if (swtick) begin
			d.stopwatch_go = q.swgo;
			if (q.stopwatch_go) begin
				if (q.swh < `CCAS_D9) begin
					d.swh = q.swh + 4'h1;
				end else begin
					d.swh = 4'h0;
					d.swt = (q.swt < `CCAS_D9) ? q.swt + 4'h1 : 4'h0;
				end
			end
		end

		d.match = q.st == q.ast && q.su == q.asu && q.mt == q.amt && q.mu == q.amu
			&& q.ht == q.aht && q.hu == q.ahu && (q.fmt || q.pm == q.apm);

		rv = 16'h0000;
		unique case (q.addr)
			`CCAS_A_CTL: begin
				rv[`CCAS_B_TRMB] = trim_busy;
				rv[`CCAS_B_BSY] = q.busy;
				rv[`CCAS_B_HLD] = q.hold;
				rv[`CCAS_B_FMT] = q.fmt;
				rv[`CCAS_B_ADJ] = q.adj;
				rv[`CCAS_B_RST] = q.rst;
				rv[`CCAS_B_RUN] = q.run;
			end
			`CCAS_A_ALS: begin
				rv[`CCAS_F_HI] = q.ast;
				rv[`CCAS_F_LO] = q.asu;
			end
			`CCAS_A_ALHM: begin
				rv[`CCAS_B_PM] = q.apm;
				rv[`CCAS_F_HT] = q.aht;
				rv[`CCAS_F_LO] = q.ahu;
				rv[`CCAS_F_MT] = q.amt;
				rv[`CCAS_F_MU] = q.amu;
			end
			`CCAS_A_SW: begin
				rv[`CCAS_F_SWT] = q.swt;
				rv[`CCAS_F_LO] = q.swh;
				rv[`CCAS_B_GO] = q.swgo;
			end
			`CCAS_A_SEC: begin
				rv[`CCAS_F_HI] = q.st;
				rv[`CCAS_F_LO] = q.su;
				rv[`CCAS_F_TAP] = q.div;
			end
			`CCAS_A_HM: begin
				rv[`CCAS_B_PM] = q.pm;
				rv[`CCAS_F_HT] = q.ht;
				rv[`CCAS_F_LO] = q.hu;
				rv[`CCAS_F_MT] = q.mt;
				rv[`CCAS_F_MU] = q.mu;
			end
			default: begin
				rv = 16'h0000;
			end
		endcase

		// ==========================================
		// Bus slave, one wait state per transfer
		d.rdy = 1'b1;
		d.bus = CCAS_BUS_IDLE;
		if (q.bus == CCAS_BUS_DATA) begin
			if (!q.wr) begin
				d.rdata = {16'h0000, rv};
			end else begin
				unique case (q.addr)
					`CCAS_A_CTL: begin
						d.hold = hwdata[`CCAS_B_HLD];
						d.fmt = hwdata[`CCAS_B_FMT];
						d.run = hwdata[`CCAS_B_RUN];
						if (hwdata[`CCAS_B_ADJ]) begin
							d.adj = 1'b1;
						end
						if (hwdata[`CCAS_B_RST]) begin
							d.rst = 1'b1;
						end
					end
					`CCAS_A_ALS: begin
						d.ast = hwdata[`CCAS_F_HI];
						d.asu = hwdata[`CCAS_F_LO];
					end
					`CCAS_A_ALHM: begin
						d.apm = hwdata[`CCAS_B_PM];
						d.aht = hwdata[`CCAS_F_HT];
						d.ahu = hwdata[`CCAS_F_LO];
						d.amt = hwdata[`CCAS_F_MT];
						d.amu = hwdata[`CCAS_F_MU];
					end
					`CCAS_A_SW: begin
						if (hwdata[`CCAS_B_CLR]) begin
							d.swt = 4'h0;
							d.swh = 4'h0;
						end
						d.swgo = hwdata[`CCAS_B_GO];
					end
					`CCAS_A_SEC: begin
						d.st = hwdata[`CCAS_F_HI];
						d.su = hwdata[`CCAS_F_LO];
					end
					`CCAS_A_HM: begin
						d.pm = hwdata[`CCAS_B_PM] && !q.fmt;
						d.ht = hwdata[`CCAS_F_HT];
						d.hu = hwdata[`CCAS_F_LO];
						d.mt = hwdata[`CCAS_F_MT];
						d.mu = hwdata[`CCAS_F_MU];
					end
					default: begin
						d.rdata = q.rdata;
					end
				endcase
			end
		end else if (hsel && hready && htrans[1]) begin
			d.bus = CCAS_BUS_DATA;
			d.addr = haddr[7:0];
			d.wr = hwrite && hsize == `CCAS_HSIZE_W;
			d.rdy = 1'b0;
		end

		if (trim_busy) begin
			d.hold = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= S_RST;
		end else begin
			q <= d;
		end
	end

	assign hrdata = q.rdata;
	assign hreadyout = q.rdy;
	assign hresp = 1'b0;
	assign alarm_match = q.match;

	// ==========================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence addr_phase;
		hsel && hready && htrans[1] && q.bus == CCAS_BUS_IDLE;
	endsequence

	sequence wait_then_done;
		!hreadyout ##1 hreadyout;
	endsequence

	bus_wait_a: assert property (addr_phase |=> wait_then_done)
		else $error("bus answer not after one wait state");

	hold_trim_a: assert property (trim_busy |=> !q.hold)
		else $error("hold set while trim busy");

	hold_freeze_a: assert property (q.hold && !q.adj && !q.rst && tick |=> !q.busy)
		else $error("count step during hold");

	busy_end_a: assert property ($fell(q.busy) |-> $past(tick))
		else $error("busy ended off the divider tick");

	adj_sec_a: assert property (q.adj && !q.busy && tick && !q.rst && !wr_now
		|=> q.st == 3'h0 && q.su == 4'h0 && q.busy && q.adj)
		else $error("half-minute correction did not clear seconds");

	adj_min_a: assert property (q.adj && !q.busy && tick && !q.rst && !wr_now
		&& q.st >= `CCAS_ADJ_MIN |=> {q.mt, q.mu} != $past({q.mt, q.mu}))
		else $error("half-minute correction missed minute step");

	rst_clear_a: assert property (q.rst |=> q.div == 8'h00 && !q.adj && !q.hold && !q.rst)
		else $error("subsecond reset incomplete");

	run_stop_a: assert property (!q.run && !q.adj && !q.pend && !wr_now
		|=> $stable({q.st, q.su}))
		else $error("seconds moved while stopped");

	pm_24h_a: assert property (q.fmt && wr_now && q.addr == `CCAS_A_HM |=> !q.pm)
		else $error("pm set in 24-hour mode");

	sw_clear_a: assert property (wr_now && q.addr == `CCAS_A_SW && hwdata[`CCAS_B_CLR]
		|=> q.swt == 4'h0 && q.swh == 4'h0)
		else $error("stopwatch clear failed");

	sw_hold_a: assert property (!q.stopwatch_go && !wr_now |=> $stable({q.swt, q.swh}))
		else $error("stopped stopwatch moved");

endmodule

`default_nettype wire

// file: tb/ccas_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic hwrite;
	logic trim_busy;
	logic hreadyout;
	logic hresp;
	logic alarm_match;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] r;
	int error_cnt;
	int checks_done;

	ccas_top #(.TICK_CYC(8), .SW_CYC(20)) ccas_top_i (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.trim_busy(trim_busy),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.alarm_match(alarm_match)
	);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// ==========================================
	// Common tasks
	task conclude;
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single AHB word transfer; waits on hready with a bound
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, d};
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		q = hrdata;
		if (n >= 100) begin
			error_cnt++;
			$display("mismatch at %0t: bus hang", $time);
			conclude();
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rd(input logic [7:0] a);
		bus(1'b0, a, 16'h0000, r);
	endtask

	// Reads until two reads in a row agree, for counters that run
	task rd2(input logic [7:0] a);
		logic [31:0] p;
		int i;
		i = 0;
		rd(a);
		p = r;
		rd(a);
		while (r !== p && i < 10) begin
			p = r;
			rd(a);
			i++;
		end
		chk(r, p);
	endtask

	task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want, input int lim);
		int i;
		i = 0;
		rd(a);
		while ((r & m) !== want && i < lim) begin
			rd(a);
			i++;
		end
		chk(r & m, want);
	endtask

	// ==========================================
	// Scenarios
	task t_reset;
		chk(alarm_match, 1'b0);
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4));
			// Divider taps run freely, only the digits are fixed
			chk(r & ((i == 4) ? 32'hFFFFFF00 : 32'hFFFFFFFF), (i == 5) ? 32'h00001200 : 32'h00000000);
		end
		chk(hresp, 1'b0);
	endtask

	task t_regs;
		wr(8'h04, 16'hFFFF);
		rd(8'h04);
		chk(r, 32'h00007F00);
		wr(8'h08, 16'hFFFF);
		rd(8'h08);
		chk(r, 32'h00007F7F);
		wr(8'h18, 16'hFFFF);
		rd(8'h18);
		chk(r, 32'h00000000);
	endtask

	task t_trim;
		trim_busy <= 1'b1;
		wr(8'h00, 16'h0020);
		rd(8'h00);
		chk(r, 32'h00008000);
		trim_busy <= 1'b0;
		wr(8'h00, 16'h0020);
		rd(8'h00);
		chk(r, 32'h00000020);
		wr(8'h00, 16'h0000);
	endtask

	task t_adjust;
		wr(8'h10, 16'h3500);
		wr(8'h14, 16'h1200);
		wr(8'h00, 16'h0004);
		rd(8'h00);
		chk(r & 32'h4, 32'h4);
		poll(8'h00, 32'h40, 32'h40, 10);
		poll(8'h00, 32'h44, 32'h0, 20);
		rd(8'h10);
		chk(r & 32'h7F00, 32'h0);
		rd(8'h14);
		chk(r, 32'h00001201);
		wr(8'h10, 16'h2900);
		wr(8'h00, 16'h0004);
		poll(8'h00, 32'h44, 32'h0, 20);
		rd(8'h10);
		chk(r & 32'h7F00, 32'h0);
		rd(8'h14);
		chk(r, 32'h00001201);
	endtask

	task t_count;
		wr(8'h00, 16'h0002);
		rd(8'h10);
		chk(r & 32'hFF, 32'h0);
		rd(8'h00);
		chk(r & 32'h2, 32'h0);
		wr(8'h04, 16'h0200);
		wr(8'h08, 16'h1200);
		wr(8'h14, 16'h1200);
		wr(8'h10, 16'h0000);
		wr(8'h00, 16'h0001);
		poll(8'h10, 32'h7F00, 32'h0100, 1000);
		wr(8'h00, 16'h0021);
		repeat (2200) @(posedge hclk);
		rd(8'h10);
		chk(r & 32'h7F00, 32'h0100);
		wr(8'h00, 16'h0001);
		poll(8'h10, 32'h7F00, 32'h0200, 30);
		repeat (3) @(posedge hclk);
		chk(alarm_match, 1'b1);
		repeat (100) @(posedge hclk);
		rd(8'h10);
		chk(r & 32'h7F00, 32'h0200);
		wr(8'h00, 16'h0000);
		repeat (2200) @(posedge hclk);
		rd(8'h10);
		chk(r & 32'h7F00, 32'h0200);
	endtask

	task t_fmt;
		wr(8'h00, 16'h0010);
		rd(8'h14);
		chk(r, 32'h00001200);
		wr(8'h14, 16'h6359);
		rd(8'h14);
		chk(r, 32'h00002359);
		rd(8'h00);
		chk(r, 32'h00000010);
		wr(8'h04, 16'h0200);
		wr(8'h08, 16'h6359);
		repeat (2) @(posedge hclk);
		chk(alarm_match, 1'b1);
		wr(8'h00, 16'h0000);
		wr(8'h14, 16'h5259);
		wr(8'h00, 16'h0010);
		wr(8'h10, 16'h5900);
		rd(8'h14);
		chk(r, 32'h00005259);
		wr(8'h00, 16'h0011);
		poll(8'h14, 32'hFFFF, 32'h1300, 1000);
		wr(8'h00, 16'h0010);
	endtask

	task t_sw;
		logic [31:0] s;
		wr(8'h0C, 16'h0001);
		repeat (100) @(posedge hclk);
		rd2(8'h0C);
		chk(r & 32'h00FF, 32'h0001);
		chk(r[15:8] !== 8'h00, 1'b1);
		wr(8'h0C, 16'h0011);
		rd2(8'h0C);
		chk(r & 32'hF0FF, 32'h0001);
		wr(8'h0C, 16'h0000);
		repeat (50) @(posedge hclk);
		rd(8'h0C);
		s = r;
		repeat (50) @(posedge hclk);
		rd(8'h0C);
		chk(r, s);
		wr(8'h0C, 16'h0010);
		rd(8'h0C);
		chk(r, 32'h00000000);
		repeat (50) @(posedge hclk);
		rd(8'h0C);
		chk(r, 32'h00000000);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		trim_busy = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		htrans = 2'h0;
		hsize = 3'h2;
		error_cnt = 0;
		checks_done = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_regs();
		t_trim();
		t_adjust();
		t_count();
		t_fmt();
		t_sw();
		conclude();
	end
endmodule
`default_nettype wire
